//--- iidt_assertions.sv
// ****
// bus handshake and run checks
// ****
module iidt_assertions (
   input logic core_clk, // clock
   input logic nrst, // reset
   input logic s_axi_awvalid, // aw valid
   input logic s_axi_awready, // aw ready
   input logic s_axi_wvalid, // w valid
   input logic s_axi_wready, // w ready
   input logic s_axi_bvalid, // b valid
   input logic s_axi_bready, // b ready
   input logic s_axi_arvalid, // ar valid
   input logic s_axi_arready, // ar ready
   input logic [31:0] s_axi_rdata, // read data
   input logic [1:0] s_axi_rresp, // read code
   input logic s_axi_rvalid, // r valid
   input logic s_axi_rready, // r ready
   input logic busy, // run active
   input logic done // end pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // one domain, so one clock and one reset for all
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_b_next;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_next: assert property (p_b_next) else $error("write answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_next;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_next: assert property (p_r_next) else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_ar_shut;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_shut: assert property (p_ar_shut) else $error("read taken while answering");
   property p_aw_shut;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_shut: assert property (p_aw_shut) else $error("write taken while answering");
   property p_done_one;
      done |=> !done;
   endproperty
   a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
   property p_done_end;
      done |-> !busy && $past(busy);
   endproperty
   a_done_end: assert property (p_done_end) else $error("done without run end");
   property p_dec_zero;
      s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0;
   endproperty
   a_dec_zero: assert property (p_dec_zero) else $error("refused read not zero");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_done: cover property (done);
endmodule

//--- iidt_core.v
`include "iidt_defs.vh"

// Contract
// - miss penalties assume a 2-1-2 bus with zero wait states
// - slower first read adds r minus 2 to the first doubleword miss penalty
// - every misaligned access adds three clocks
// - access to a line being filled stalls until the fill completes
// - base register written by previous instruction adds one clock
// - an index register in the address adds one clock
// - uncached jump target adds r, up to 3b more, then r+3b more
// - waiting for the write buffer to drain adds w clocks
// - displacement together with immediate adds one clock
// - each contending invalidate cycle adds one clock
// - tlb miss adds 13, 21 or 28 clocks by entries needing update
// - unaligned multi-item read miss adds an extra fill of r+3b
// - opcode 1000101w loads memory into register, 1 clock, miss 2
// - opcode 1000100w stores register to memory in 1 clock
// - 0f then 1011z11w extends zero or sign, 3 clocks, miss 2
// - ff with field 110 pushes memory, 4 clocks, miss 1
// - 8f with field 000 pops to memory, 6 clocks, miss 2
// - opcode 1000011w swaps register with memory in 5 clocks
// - opcode 8d loads effective address, 1 clock, 2 with index
// - alu field: add 000 or 001 adc 010 sbb 011 and 100 sub 101 xor 110
// - opcode 1100011w field 000 moves immediate to memory in 1 clock
module iidt_core (
   input wire core_clk, // 50 mhz clock
   input wire nrst, // async reset, active low
   input wire fill_busy, // line fill in progress, async pin
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output reg s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output reg s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output reg s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   output reg busy, // timing run in progress
   output reg done // one-cycle pulse at end of run
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_COUNT = 3'b100;

   reg [23:0] instr;
   reg [16:0] cond;
   reg [3:0] bus_r;
   reg [3:0] bus_b;
   reg [3:0] bus_w;
   reg [2:0] state;
   reg [7:0] remain;
   reg [7:0] total;
   reg [3:0] cls;
   reg wide;
   reg sext;
   reg [2:0] alu_op;
   reg valid;
   reg fill_s1;
   reg fill_s2;
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   // ************************************************
   // decode
   // ************************************************
   reg [3:0] next_cls;
   reg [7:0] base_clk;
   reg [7:0] miss_clk;
   reg [7:0] next_total;
   reg [7:0] r8;
   reg [7:0] b3;
   wire [7:0] op0 = instr[7:0];
   wire [7:0] op1 = instr[15:8];
   wire [7:0] mrm = op0 == `IIDT_OP_ESC ? instr[23:16] : op1;
   wire mem_form = mrm[7:6] != 2'b11;
   wire [1:0] span = cond[`IIDT_C_SPAN_HI:`IIDT_C_SPAN_LO];
   wire [1:0] ad = cond[`IIDT_C_AD_HI:`IIDT_C_AD_LO];

   // byte lane merge, shared by every writable register
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = dat[i*8 +: 8];
            end
         end
      end
   endfunction

   // class and base/miss clocks from the opcode bytes
   always @* begin
      next_cls = `IIDT_CL_NONE;
      base_clk = 8'h00;
      miss_clk = 8'h00;
      if (op0[7:1] == `IIDT_OP_LOAD) begin
         next_cls = `IIDT_CL_LOAD;
         base_clk = 8'h01;
         miss_clk = 8'h02;
      end else if (op0[7:1] == `IIDT_OP_STORE) begin
         next_cls = `IIDT_CL_STORE;
         base_clk = 8'h01;
      end else if (op0 == `IIDT_OP_ESC && op1[7:4] == 4'hb && op1[2:1] == 2'b11) begin
         next_cls = `IIDT_CL_EXT;
         base_clk = 8'h03;
         miss_clk = 8'h02;
      end else if (op0 == `IIDT_OP_PUSHM && op1[5:3] == `IIDT_FLD_PUSH) begin
         next_cls = `IIDT_CL_PUSH;
         base_clk = 8'h04;
         miss_clk = 8'h01;
      end else if (op0 == `IIDT_OP_POPM && op1[5:3] == `IIDT_FLD_ZERO) begin
         next_cls = `IIDT_CL_POP;
         base_clk = mem_form ? 8'h06 : 8'h04;
         miss_clk = mem_form ? 8'h02 : 8'h01;
      end else if (op0[7:1] == `IIDT_OP_SWAP) begin
         next_cls = `IIDT_CL_SWAP;
         base_clk = mem_form ? 8'h05 : 8'h03;
      end else if (op0 == `IIDT_OP_LEA) begin
         next_cls = `IIDT_CL_LEA;
         base_clk = 8'h01;
      end else if (op0[7:1] == `IIDT_OP_IMMMEM && op1[5:3] == `IIDT_FLD_ZERO) begin
         next_cls = `IIDT_CL_IMMMEM;
         base_clk = 8'h01;
      end else if (op0[7:6] == 2'b00 && op0[2] == 1'b0 && op0[5:3] != 3'h7) begin
         // alu register and memory forms; field 111 is compare, outside this block
         next_cls = `IIDT_CL_ALU;
         base_clk = !mem_form ? 8'h01 : (op0[1] ? 8'h02 : 8'h03);
         miss_clk = 8'h02;
      end
      // register forms never touch the data cache; pop still reads the stack,
      // so its register form keeps its own miss figure
      if (!mem_form && next_cls != `IIDT_CL_LEA && next_cls != `IIDT_CL_POP) begin
         miss_clk = 8'h00;
      end
   end

   // penalty sum; base miss figures already assume the 2-1-2 bus
   // 8-bit sum wraps silently; totals beyond 255 are outside this model
   always @* begin
      r8 = {4'h0, bus_r};
      b3 = {4'h0, bus_b} + {4'h0, bus_b} + {4'h0, bus_b};
      next_total = base_clk;
      if (cond[`IIDT_C_MISS] && miss_clk != 8'h00) begin
         next_total = next_total + miss_clk + r8 - `IIDT_R_FAST;
         if (cond[`IIDT_C_MULTI]) begin
            next_total = next_total + r8 + b3;
         end
      end
      if (cond[`IIDT_C_MISAL]) begin
         next_total = next_total + `IIDT_MISAL_CLK;
      end
      if (cond[`IIDT_C_BASEDEP] && mem_form) begin
         next_total = next_total + 8'h01;
      end
      if (cond[`IIDT_C_INDEX] && mem_form) begin
         next_total = next_total + 8'h01;
      end
      if (cond[`IIDT_C_JMPNC]) begin
         next_total = next_total + r8;
         if (span != 2'b00) begin
            next_total = next_total + b3;
         end
         if (span[1]) begin
            next_total = next_total + r8 + b3;
         end
      end
      if (cond[`IIDT_C_WBUF]) begin
         next_total = next_total + {4'h0, bus_w};
      end
      if (cond[`IIDT_C_DISPIMM]) begin
         next_total = next_total + 8'h01;
      end
      next_total = next_total + {4'h0, cond[`IIDT_C_INV_HI:`IIDT_C_INV_LO]};
      if (cond[`IIDT_C_TLB]) begin
         if (ad == 2'b00) begin
            next_total = next_total + `IIDT_TLB0_CLK;
         end else if (ad == 2'b01) begin
            next_total = next_total + `IIDT_TLB1_CLK;
         end else begin
            next_total = next_total + `IIDT_TLB2_CLK;
         end
      end
   end

   // ************************************************
   // register bus
   // ************************************************
   wire wr_go = aw_held && w_held && !s_axi_bvalid;
   wire start_wr = wr_go && aw_addr == `IIDT_OFS_CTRL && w_strb[0] && w_data[0];

   // each stored field merged by byte lane, then cut back to its own width
   wire [31:0] instr_word = merge({8'h00, instr}, w_data, w_strb);
   wire [31:0] cond_word = merge({15'h0000, cond}, w_data, w_strb);
   wire [31:0] bus_word = merge({20'h00000, bus_w, bus_b, bus_r}, w_data, w_strb);

   // write channels taken in either order, answered once both are held
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IIDT_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         instr <= 24'h000000;
         cond <= 17'h00000;
         bus_r <= `IIDT_R_RST;
         bus_b <= `IIDT_B_RST;
         bus_w <= `IIDT_W_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `IIDT_RESP_OKAY;
            if (aw_addr == `IIDT_OFS_INSTR) begin
               instr <= instr_word[23:0];
            end else if (aw_addr == `IIDT_OFS_COND) begin
               cond <= cond_word[16:0];
            end else if (aw_addr == `IIDT_OFS_BUS) begin
               {bus_w, bus_b, bus_r} <= bus_word[11:0];
            end else if (aw_addr == `IIDT_OFS_CTRL || aw_addr == `IIDT_OFS_STATUS ||
                         aw_addr == `IIDT_OFS_REMAIN) begin
               s_axi_bresp <= `IIDT_RESP_OKAY; // start or read-only, no storage
            end else begin
               s_axi_bresp <= `IIDT_RESP_DECERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read answer one cycle after the address is taken
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `IIDT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `IIDT_RESP_OKAY;
         // rdata only moves when an address is taken, so it stands for the answer
         if (s_axi_araddr == `IIDT_OFS_INSTR) begin
            s_axi_rdata <= {8'h00, instr};
         end else if (s_axi_araddr == `IIDT_OFS_COND) begin
            s_axi_rdata <= {15'h0000, cond};
         end else if (s_axi_araddr == `IIDT_OFS_BUS) begin
            s_axi_rdata <= {20'h00000, bus_w, bus_b, bus_r};
         end else if (s_axi_araddr == `IIDT_OFS_CTRL) begin
            s_axi_rdata <= 32'h00000000;
         end else if (s_axi_araddr == `IIDT_OFS_STATUS) begin
            // upper byte and bits 15:11 read as zero
            s_axi_rdata <= {8'h00, total, 5'h00, alu_op, cls,
                            sext, wide, valid, busy};
         end else if (s_axi_araddr == `IIDT_OFS_REMAIN) begin
            s_axi_rdata <= {24'h000000, remain};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `IIDT_RESP_DECERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ************************************************
   // timing run
   // ************************************************
   // two-stage sync on the fill pin before anything reads it
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fill_s1 <= 1'b0;
         fill_s2 <= 1'b0;
      end else begin
         fill_s1 <= fill_busy;
         fill_s2 <= fill_s1;
      end
   end

   // start latches decode, waits out any fill if the operand is in memory, then counts the clocks down
   // start to done spans the total plus the wait and count entry edges
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         remain <= 8'h00;
         total <= 8'h00;
         cls <= `IIDT_CL_NONE;
         wide <= 1'b0;
         sext <= 1'b0;
         alu_op <= 3'h0;
         valid <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            ST_IDLE: begin
               // a start written while busy lands outside idle and is dropped
               if (start_wr) begin
                  cls <= next_cls;
                  total <= next_total;
                  remain <= next_total;
                  wide <= op0 == `IIDT_OP_ESC ? op1[0] : op0[0];
                  sext <= op0 == `IIDT_OP_ESC && op1[3];
                  alu_op <= op0[5:3];
                  valid <= 1'b0;
                  busy <= 1'b1;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // a memory access must not overtake a fill in progress
               if (!(fill_s2 && mem_form)) begin
                  state <= ST_COUNT;
               end
            end
            ST_COUNT: begin
               // zero and one both end here, so every run counts at least once
               if (remain <= 8'h01) begin
                  remain <= 8'h00;
                  valid <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  remain <= remain - 8'h01;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

//--- iidt_defs.vh
`ifndef IIDT_DEFS_VH
`define IIDT_DEFS_VH
// register byte offsets
`define IIDT_OFS_INSTR 8'h00
`define IIDT_OFS_COND 8'h04
`define IIDT_OFS_BUS 8'h08
`define IIDT_OFS_CTRL 8'h0c
`define IIDT_OFS_STATUS 8'h10
`define IIDT_OFS_REMAIN 8'h14
// bus timing reset values, fastest bus 2-1-2
`define IIDT_R_RST 4'h2
`define IIDT_B_RST 4'h1
`define IIDT_W_RST 4'h2
`define IIDT_R_FAST 8'h02
// condition register field positions
`define IIDT_C_MISS 0
`define IIDT_C_MISAL 1
`define IIDT_C_BASEDEP 2
`define IIDT_C_INDEX 3
`define IIDT_C_JMPNC 4
`define IIDT_C_SPAN_LO 5
`define IIDT_C_SPAN_HI 6
`define IIDT_C_WBUF 7
`define IIDT_C_DISPIMM 8
`define IIDT_C_INV_LO 9
`define IIDT_C_INV_HI 12
`define IIDT_C_TLB 13
`define IIDT_C_AD_LO 14
`define IIDT_C_AD_HI 15
`define IIDT_C_MULTI 16
// penalties in clocks
`define IIDT_MISAL_CLK 8'h03
`define IIDT_TLB0_CLK 8'h0d
`define IIDT_TLB1_CLK 8'h15
`define IIDT_TLB2_CLK 8'h1c
// opcodes, upper seven bits where w is the low bit
`define IIDT_OP_LOAD 7'h45
`define IIDT_OP_STORE 7'h44
`define IIDT_OP_SWAP 7'h43
`define IIDT_OP_IMMMEM 7'h63
`define IIDT_OP_ESC 8'h0f
`define IIDT_OP_PUSHM 8'hff
`define IIDT_OP_POPM 8'h8f
`define IIDT_OP_LEA 8'h8d
`define IIDT_FLD_PUSH 3'h6
`define IIDT_FLD_ZERO 3'h0
// instruction classes
`define IIDT_CL_NONE 4'h0
`define IIDT_CL_LOAD 4'h1
`define IIDT_CL_STORE 4'h2
`define IIDT_CL_EXT 4'h3
`define IIDT_CL_PUSH 4'h4
`define IIDT_CL_POP 4'h5
`define IIDT_CL_SWAP 4'h6
`define IIDT_CL_LEA 4'h7
`define IIDT_CL_IMMMEM 4'h8
`define IIDT_CL_ALU 4'h9
// alu operation field codes
`define IIDT_ALU_ADD 3'h0
`define IIDT_ALU_OR 3'h1
`define IIDT_ALU_ADC 3'h2
`define IIDT_ALU_SBB 3'h3
`define IIDT_ALU_AND 3'h4
`define IIDT_ALU_SUB 3'h5
`define IIDT_ALU_XOR 3'h6
// bus answers
`define IIDT_RESP_OKAY 2'h0
`define IIDT_RESP_DECERR 2'h3
`endif

//--- iidt_fill_bus.sv
// ****
// burst bus serving line fills
// ****
module iidt_fill_bus #(
   parameter int R = 2, // first read clocks
   parameter int B = 1 // later beat clocks
) (
   input logic core_clk, // clock
   input logic nrst, // reset
   input logic fill_req, // start a fill
   input logic [7:0] fill_extra, // wait states, slow answer
   output logic fill_busy // fill running
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left;
   // a 16-byte fill is one first read and three burst beats
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         left <= 8'h00;
      end else if (fill_req && left == 8'h00) begin
         left <= 8'(R + 3 * B) + fill_extra;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign fill_busy = (left != 8'h00);
endmodule

//--- test_integer_instr_decode_timing.sv
`include "iidt_defs.vh"
module test_integer_instr_decode_timing;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [23:0] ins; logic [16:0] cnd; logic [31:0] st;} iidt_row_t;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fill_req = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, fill_extra = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic busy, done, fill_busy;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, seen;
   int fails = 0, total_checks = 0, cycles = 0, fill_end, done_at;
   iidt_row_t rows [$];
   iidt_core dut (.*);
   iidt_fill_bus #(.R(2), .B(1)) u_bus (.core_clk(core_clk), .nrst(nrst),
      .fill_req(fill_req), .fill_extra(fill_extra), .fill_busy(fill_busy));
   // clock and hang guard
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         finish_test();
      end
   end
   // ****
   // tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // requests change just after a rising edge and hold until taken at one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge core_clk);
         if (!ta && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            ta = 1'b1;
         end
         if (!tw && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            tw = 1'b1;
         end
      end
      do @(posedge core_clk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      seen = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // load one case, start it, wait for the end and fetch status
   task automatic run(input iidt_row_t r);
      wr(`IIDT_OFS_INSTR, {8'h0, r.ins});
      wr(`IIDT_OFS_COND, {15'h0, r.cnd});
      wr(`IIDT_OFS_CTRL, 32'h1);
      do @(negedge core_clk); while (!done);
      done_at = cycles;
      rd(`IIDT_OFS_STATUS);
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      rows = '{
         '{24'h8b, 17'h0, 32'h10016},
         '{24'h8a, 17'h1, 32'h30012},
         '{24'h89, 17'h2, 32'h40026},
         '{24'hb70f, 17'h1, 32'h50036},
         '{24'hbf0f, 17'h0, 32'h3003e},
         '{24'h30ff, 17'h1, 32'h50046},
         '{24'h8f, 17'h4, 32'h70056},
         '{24'h87, 17'h8, 32'h60066},
         '{24'h8d, 17'h8, 32'h20076},
         '{24'hc7, 17'h100, 32'h20086},
         '{24'h8b, 17'h2000, 32'he0016},
         '{24'h8b, 17'h6000, 32'h160016},
         '{24'h8b, 17'ha000, 32'h1d0016},
         '{24'h8b, 17'ha00, 32'h60016},
         '{24'h8b, 17'h80, 32'h30016},
         '{24'h8b, 17'h10, 32'h30016},
         '{24'h8b, 17'h30, 32'h60016},
         '{24'h8b, 17'h50, 32'hb0016},
         '{24'h8b, 17'h10001, 32'h80016},
         '{24'hc087, 17'h1, 32'h30066},
         '{24'hc08f, 17'h1, 32'h50056},
         '{24'hc003, 17'h5, 32'h10096}};
      // every alu field code in the memory-to-register form
      for (int t = 0; t < 7; t++) begin
         rows.push_back('{{16'h0, 2'b00, t[2:0], 3'b011}, 17'h0, 32'h20096 | (32'(t) << 8)});
      end
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      rd(`IIDT_OFS_BUS);
      chk(seen, 32'h212);
      foreach (rows[i]) begin
         run(rows[i]);
         chk(seen & ((rows[i].st[7:4] == 4'h9) ? 32'hff07fe : 32'hff00fe), rows[i].st);
      end
      // unmapped place refused both ways, control reads zero
      rd(8'h18);
      chk({seen[31:2], resp}, 32'h3);
      wr(8'h18, 32'hffffffff);
      chk({30'h0, resp}, 32'h3);
      rd(`IIDT_OFS_CTRL);
      chk(seen, 32'h0);
      // slower first read
      wr(`IIDT_OFS_BUS, 32'h214);
      run('{24'h8b, 17'h1, 32'h0});
      chk(seen & 32'hff00fe, 32'h50016);
      // access during a running fill waits for it
      @(posedge core_clk);
      fill_req <= 1'b1;
      fill_extra <= 8'd40;
      @(posedge core_clk);
      fill_req <= 1'b0;
      fill_end = cycles + 40;
      run('{24'h8b, 17'h0, 32'h0});
      chk(32'(done_at > fill_end), 32'h1);
      chk(seen & 32'hff00fe, 32'h10016);
      // reset in mid-run of a long tlb case clears the run and reloads the 2-1-2 bus timing
      wr(`IIDT_OFS_COND, 32'ha000);
      wr(`IIDT_OFS_CTRL, 32'h1);
      chk({31'h0, busy}, 32'h1);
      repeat (3) @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({31'h0, busy}, 32'h0);
      nrst <= 1'b1;
      rd(`IIDT_OFS_BUS);
      chk(seen, 32'h212);
      rd(`IIDT_OFS_STATUS);
      chk(seen, 32'h0);
      finish_test();
   end
endmodule
bind iidt_core iidt_assertions u_chk (.*);
